// [tct_top.sv]
// Thermal clock throttle: automatic and software clock modulation, hot alert pin, trip.
// Assumes sensor comparator levels arrive asynchronously; register port is same-clock.
`timescale 1ns/1ps

module tct_top
    import tct_pkg::*;
#(
    parameter logic [15:0] HYST_CYCLES     = 16'(HYST_CYC),
    parameter logic [2:0]  AUTO_ON_EIGHTHS = 3'(AUTO_ON_DEF),
    parameter logic [7:0]  FAN_SETPOINT    = FAN_DEF
)
(
    input  wire logic        sys_clk_i,
    input  wire logic        resetn_i,
    input  wire logic        clk_en_i,
    input  wire logic        die_hot_i,
    input  wire logic        die_trip_i,
    input  wire logic        auto_en_i,
    input  wire logic        hot_alert_n_i,
    input  wire logic        irq_on_assert_i,
    input  wire logic        irq_on_deassert_i,
    input  wire logic        int_req_i,
    input  wire logic        snoop_req_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    input  wire logic        reg_sel_i,
    input  wire logic [63:0] reg_wdata_i,
    output logic [63:0]      reg_rdata_o,
    output logic             core_clk_en_o,
    output logic             hot_alert_n_o,
    output logic             hot_alert_n_oe_o,
    output logic             hot_irq_o,
    output logic             int_service_o,
    output logic             snoop_ack_o,
    output logic             throttle_active_o,
    output logic             overheat_shutdown_n_o
);

    ////////////////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        logic [2:0]  die_sync;
        logic [2:0]  trip_sync;
        logic [2:0]  pin_sync;
        logic        die_hot;
        logic        trip;
        logic        pin_low;
        tct_auto_e   eng;
        logic [15:0] hyst_cnt;
        logic [3:0]  modctl;
        logic [7:0]  slot_cnt;
        logic [2:0]  phase;
        logic        clk_on;
        logic        drive_low;
        logic        alert_n;
        logic        shut_n;
        logic        int_pend;
        logic        int_srv;
        logic        hot_irq;
        logic        snoop_ack;
        logic        thr_act;
        logic [63:0] rdata;
    } tct_state_s;

    tct_state_s st_q;
    tct_state_s st_d;

    logic       hot_req;
    logic       modulate;
    logic [2:0] on_eighths;
    logic [2:0] sw_duty;
    logic       sw_en;

    ////////////////////////////////////////////////////////////////////////////////
    // Throttle source and duty selection
    always_comb
    begin
        hot_req    = st_q.die_hot | st_q.pin_low;
        sw_en      = st_q.modctl[MODCTL_EN_BIT - MODCTL_DUTY_LO];
        sw_duty    = st_q.modctl[MODCTL_DUTY_W - 1:0];
        modulate   = 1'b0;
        on_eighths = AUTO_ON_EIGHTHS;
        if (st_q.eng != TCT_IDLE)
        begin
            modulate   = 1'b1;
            on_eighths = AUTO_ON_EIGHTHS;
        end
        else if (sw_en && (sw_duty != 3'h0))
        begin
            modulate   = 1'b1;
            on_eighths = sw_duty;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb
    begin
        st_d           = st_q;
        st_d.int_srv   = 1'b0;
        st_d.hot_irq   = 1'b0;
        // Three-stage sampling of the asynchronous levels
        st_d.die_sync  = {st_q.die_sync[1:0], die_hot_i};
        st_d.trip_sync = {st_q.trip_sync[1:0], die_trip_i};
        st_d.pin_sync  = {st_q.pin_sync[1:0], ~hot_alert_n_i};
        if (st_q.die_sync[1] == st_q.die_sync[2])
        begin
            st_d.die_hot = st_q.die_sync[2];
        end
        if (st_q.pin_sync[1] == st_q.pin_sync[2])
        begin
            st_d.pin_low = st_q.pin_sync[2];
        end
        if ((st_q.trip_sync[1] == st_q.trip_sync[2]) && st_q.trip_sync[2])
        begin
            st_d.trip = 1'b1;
        end
        // Hot alert edge interrupts
        if (st_d.pin_low && !st_q.pin_low && irq_on_assert_i)
        begin
            st_d.hot_irq = 1'b1;
        end
        if (!st_d.pin_low && st_q.pin_low && irq_on_deassert_i)
        begin
            st_d.hot_irq = 1'b1;
        end
        // Hot alert drive
        st_d.drive_low = st_q.die_hot;
        st_d.alert_n   = ~st_q.die_hot;
        // Automatic engine, needs no software once enabled
        case (st_q.eng)
            TCT_IDLE:
            begin
                if (auto_en_i && hot_req)
                begin
                    st_d.eng = TCT_ACTIVE;
                end
            end
            TCT_ACTIVE:
            begin
                if (!auto_en_i)
                begin
                    st_d.eng = TCT_IDLE;
                end
                else if (!hot_req)
                begin
                    st_d.eng      = TCT_HOLD;
                    st_d.hyst_cnt = HYST_CYCLES - 16'h0001;
                end
            end
            TCT_HOLD:
            begin
                if (!auto_en_i)
                begin
                    st_d.eng = TCT_IDLE;
                end
                else if (hot_req)
                begin
                    st_d.eng = TCT_ACTIVE;
                end
                else if (st_q.hyst_cnt == 16'h0000)
                begin
                    st_d.eng = TCT_IDLE;
                end
                else
                begin
                    st_d.hyst_cnt = st_q.hyst_cnt - 16'h0001;
                end
            end
            default:
            begin
                st_d.eng = TCT_IDLE;
            end
        endcase
        // Slot timer and duty phase
        if (modulate)
        begin
            if (st_q.slot_cnt == 8'(SLOT_CYC - 1))
            begin
                st_d.slot_cnt = 8'h00;
                st_d.phase    = st_q.phase + 3'h1;
            end
            else
            begin
                st_d.slot_cnt = st_q.slot_cnt + 8'h01;
            end
        end
        else
        begin
            st_d.slot_cnt = 8'h00;
            st_d.phase    = 3'h0;
        end
        // Registered gate, so each change lands on a whole clock cycle
        st_d.clk_on  = !st_d.trip && (!modulate || (st_d.phase < on_eighths));
        st_d.shut_n  = !st_d.trip;
        st_d.thr_act = modulate;
        // Snoops answered regardless of gating
        st_d.snoop_ack = snoop_req_i;
        // Interrupts latched, serviced while clocks run; a new request wins
        if (st_q.int_pend && st_q.clk_on)
        begin
            st_d.int_pend = 1'b0;
            st_d.int_srv  = 1'b1;
        end
        if (int_req_i)
        begin
            st_d.int_pend = 1'b1;
        end
        // Software register port
        if (reg_wr_i && (reg_sel_i == REG_SEL_MODCTL))
        begin
            st_d.modctl = reg_wdata_i[MODCTL_EN_BIT:MODCTL_DUTY_LO];
        end
        if (reg_rd_i)
        begin
            if (reg_sel_i == REG_SEL_FAN)
            begin
                st_d.rdata = {56'h0, FAN_SETPOINT};
            end
            else
            begin
                st_d.rdata = {59'h0, st_q.modctl, 1'b0};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge sys_clk_i)
    begin
        if (!resetn_i)
        begin
            st_q           <= '0;
            st_q.eng       <= TCT_IDLE;
            st_q.modctl    <= MODCTL_RESET[MODCTL_EN_BIT:MODCTL_DUTY_LO];
            st_q.clk_on    <= 1'b1;
            st_q.alert_n   <= 1'b1;
            st_q.shut_n    <= 1'b1;
        end
        else if (clk_en_i)
        begin
            st_q <= st_d;
        end
    end

    assign reg_rdata_o           = st_q.rdata;
    assign core_clk_en_o         = st_q.clk_on;
    assign hot_alert_n_o         = st_q.alert_n;
    assign hot_alert_n_oe_o      = st_q.drive_low;
    assign hot_irq_o             = st_q.hot_irq;
    assign int_service_o         = st_q.int_srv;
    assign snoop_ack_o           = st_q.snoop_ack;
    assign throttle_active_o     = st_q.thr_act;
    assign overheat_shutdown_n_o = st_q.shut_n;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    tct_auto_e   eng_w;
    logic [15:0] hyst_w;
    logic [9:0]  off_run_q;

    assign eng_w  = st_q.eng;
    assign hyst_w = st_q.hyst_cnt;

    always_ff @(posedge sys_clk_i)
    begin
        if (!resetn_i || core_clk_en_o || !overheat_shutdown_n_o)
        begin
            off_run_q <= 10'h000;
        end
        else if (clk_en_i)
        begin
            off_run_q <= off_run_q + 10'h001;
        end
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i || !clk_en_i);

    sequence s_hold_done;
        eng_w == TCT_HOLD && hyst_w == 16'h0000 && !hot_req && auto_en_i;
    endsequence

    sequence s_hot_idle;
        eng_w == TCT_IDLE && auto_en_i && hot_req;
    endsequence

    trip_latched_a: assert property (!overheat_shutdown_n_o |=> !overheat_shutdown_n_o)
        else $error("shutdown output released");
    trip_stops_clk_a: assert property (!overheat_shutdown_n_o |-> !core_clk_en_o)
        else $error("clock running in shutdown");
    auto_start_a: assert property (s_hot_idle |=> eng_w == TCT_ACTIVE)
        else $error("engine did not start");
    hyst_expire_a: assert property (s_hold_done |=> eng_w == TCT_IDLE)
        else $error("engine did not stop after hold");
    hold_early_a: assert property (
        (eng_w == TCT_IDLE && $past(eng_w) == TCT_HOLD && $past(auto_en_i))
        |-> $past(hyst_w) == 16'h0000)
        else $error("engine stopped before hold expired");
    auto_duty_a: assert property (
        (eng_w != TCT_IDLE && $past(eng_w) != TCT_IDLE)
        |-> core_clk_en_o == (st_q.phase < AUTO_ON_EIGHTHS && overheat_shutdown_n_o))
        else $error("auto duty not applied");
    sw_zero_a: assert property (
        (eng_w == TCT_IDLE && sw_duty == 3'h0 && !st_q.trip)
        |=> (core_clk_en_o || !overheat_shutdown_n_o))
        else $error("clock gated with zero duty");
    hot_drive_a: assert property (st_q.die_hot |=> (hot_alert_n_oe_o && !hot_alert_n_o))
        else $error("hot alert not driven");
    int_clk_on_a: assert property (int_service_o |-> $past(core_clk_en_o))
        else $error("interrupt serviced while gated");
    int_kept_a: assert property ((st_q.int_pend && !core_clk_en_o) |=> st_q.int_pend)
        else $error("pending interrupt lost");
    edge_irq_a: assert property (
        ($rose(st_q.pin_low) && $past(irq_on_assert_i)) |-> hot_irq_o)
        else $error("no interrupt on hot alert assertion");
    off_bound_a: assert property (off_run_q <= 10'(OFF_MAX_CYC))
        else $error("clock off interval too long");

endmodule // tct_top

// [tct_pkg.sv]
// Constants shared by the thermal clock throttle.
// Assumes a 250 MHz core clock and 64-bit software register words.
package tct_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Clock rate and modulation timing
    localparam int unsigned CLK_MHZ      = 250;
    localparam int unsigned OFF_MAX_NS   = 3000;
    localparam int unsigned OFF_MAX_CYC  = OFF_MAX_NS * CLK_MHZ / 1000;
    localparam int unsigned DUTY_SLOTS   = 8;
    localparam int unsigned SLOT_CYC     = OFF_MAX_CYC / DUTY_SLOTS;
    localparam int unsigned HYST_NS      = 4000;
    localparam int unsigned HYST_CYC     = HYST_NS * CLK_MHZ / 1000;
    localparam int unsigned AUTO_ON_DEF  = 3;

    ////////////////////////////////////////////////////////////////////////////////
    // Clock modulation control register
    localparam logic [63:0] MODCTL_RESET   = 64'h0000000000000000;
    localparam int unsigned MODCTL_EN_BIT  = 4;
    localparam int unsigned MODCTL_DUTY_LO = 1;
    localparam int unsigned MODCTL_DUTY_W  = 3;

    ////////////////////////////////////////////////////////////////////////////////
    // Fan setpoint register
    localparam logic [7:0]  FAN_BASE_DEG   = 8'h32;
    localparam logic [7:0]  FAN_MAX        = 8'h1e;
    localparam logic [7:0]  FAN_DEF        = 8'h00;

    ////////////////////////////////////////////////////////////////////////////////
    // Register selection on the software access port
    localparam logic        REG_SEL_MODCTL = 1'b0;
    localparam logic        REG_SEL_FAN    = 1'b1;

    ////////////////////////////////////////////////////////////////////////////////
    // Automatic throttle engine states
    typedef enum logic [1:0] {
        TCT_IDLE,
        TCT_ACTIVE,
        TCT_HOLD
    } tct_auto_e;

endpackage

// [tct_board_model.sv]
// Board model: regulator monitor on the hot alert wire, power sequencer.
// Assumes a pulled-up wire that the device pulls low through its enable.
`timescale 1ns/1ps

module tct_board_model
(
    input  wire logic sys_clk_i,
    input  wire logic resetn_i,
    input  wire logic vr_hot_i,
    input  wire logic dev_alert_n_i,
    input  wire logic dev_alert_oe_i,
    input  wire logic shutdown_n_i,
    output logic      hot_alert_pin_o,
    output logic      core_supply_on_o
);
    logic supply_q;

    ////////////////////////////////////////
    // Wire with pull-up, either party pulls low
    assign hot_alert_pin_o = !((dev_alert_oe_i && !dev_alert_n_i) || vr_hot_i);

    // Supply cut on shutdown
    always_ff @(posedge sys_clk_i)
    begin
        if (!resetn_i)
        begin
            supply_q <= 1'b1;
        end
        else if (!shutdown_n_i)
        begin
            supply_q <= 1'b0;
        end
    end
    assign core_supply_on_o = supply_q;
endmodule // tct_board_model

// [tct_top_tb.sv]
// Self-checking bench for the thermal clock throttle.
// Assumes tct_top and tct_board_model; inputs change on falling edges.
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin n_errors++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, exp, got); end end

module tct_top_tb;
    import tct_pkg::*;
    localparam logic [15:0] HYST = 16'd40;
    localparam logic [7:0]  FANV = 8'h1e;
    localparam int          PER  = DUTY_SLOTS * SLOT_CYC;
    logic        sys_clk_i = 1'b0;
    logic        resetn_i  = 1'b0;
    logic        clk_en    = 1'b1;
    logic        die_hot   = 1'b0;
    logic        die_trip  = 1'b0;
    logic        auto_en   = 1'b0;
    logic        irq_a     = 1'b0;
    logic        irq_d     = 1'b0;
    logic        int_req   = 1'b0;
    logic        snoop_req = 1'b0;
    logic        reg_wr    = 1'b0;
    logic        reg_rd    = 1'b0;
    logic        reg_sel   = 1'b0;
    logic        vr_hot    = 1'b0;
    logic        prev_on   = 1'b1;
    logic [63:0] wdata     = 64'h0;
    logic [63:0] rdata;
    logic        clk_on, alert_n, alert_oe, hot_irq, svc, snoop_ack, thr, trip_n, pin, supply;
    int          n_errors = 0;
    int          checks   = 0;
    int          cyc      = 0;
    int          n_irq    = 0;
    int          run      = 0;
    int          max_off  = 0;
    int          svc_bad  = 0;
    int          n, i, t0;

    always #2 sys_clk_i = ~sys_clk_i;

    tct_top #(.HYST_CYCLES(HYST), .AUTO_ON_EIGHTHS(3'd3), .FAN_SETPOINT(FANV)) tct_top_inst (
        .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .clk_en_i(clk_en), .die_hot_i(die_hot),
        .die_trip_i(die_trip), .auto_en_i(auto_en), .hot_alert_n_i(pin),
        .irq_on_assert_i(irq_a), .irq_on_deassert_i(irq_d), .int_req_i(int_req),
        .snoop_req_i(snoop_req), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_sel_i(reg_sel),
        .reg_wdata_i(wdata), .reg_rdata_o(rdata), .core_clk_en_o(clk_on),
        .hot_alert_n_o(alert_n), .hot_alert_n_oe_o(alert_oe), .hot_irq_o(hot_irq),
        .int_service_o(svc), .snoop_ack_o(snoop_ack), .throttle_active_o(thr),
        .overheat_shutdown_n_o(trip_n));

    tct_board_model tct_board_model_inst (
        .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .vr_hot_i(vr_hot),
        .dev_alert_n_i(alert_n), .dev_alert_oe_i(alert_oe), .shutdown_n_i(trip_n),
        .hot_alert_pin_o(pin), .core_supply_on_o(supply));

    ////////////////////////////////////////
    // Tasks
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
        begin
            $display("*** PASS ***");
        end
        else
        begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic wr(input logic sel, input logic [63:0] d);
        reg_sel = sel;
        wdata = d;
        reg_wr = 1'b1;
        @(negedge sys_clk_i);
        reg_wr = 1'b0;
        @(negedge sys_clk_i);
    endtask

    task automatic rd(input logic sel, input logic [63:0] exp, input string nm);
        reg_sel = sel;
        reg_rd = 1'b1;
        @(negedge sys_clk_i);
        reg_rd = 1'b0;
        @(negedge sys_clk_i);
        `CHK(nm, exp, rdata)
    endtask

    task automatic on_count(input int exp, input string nm);
        n = 0;
        repeat (PER)
        begin
            @(negedge sys_clk_i);
            if (clk_on === 1'b1) n++;
        end
        `CHK(nm, exp, n)
    endtask

    // Edge irqs, service timing, longest gap, hang limit
    always @(negedge sys_clk_i)
    begin
        cyc++;
        if (hot_irq === 1'b1) n_irq++;
        if (svc === 1'b1 && prev_on !== 1'b1) svc_bad++;
        prev_on = clk_on;
        run = (clk_on === 1'b0 && trip_n === 1'b1) ? run + 1 : 0;
        if (run > max_off) max_off = run;
        if (cyc == 40000)
        begin
            n_errors++;
            tally_and_finish();
        end
    end

    ////////////////////////////////////////
    // Scenarios
    initial
    begin
        repeat (8) @(negedge sys_clk_i);
        resetn_i = 1'b1;
        @(negedge sys_clk_i);
        `CHK("rst_out", 5'b11001, {clk_on, alert_n, alert_oe, thr, trip_n})
        wr(REG_SEL_MODCTL, 64'hffff_ffff_ffff_ffe0);
        rd(REG_SEL_MODCTL, 64'h0, "ctl_masked");
        wr(REG_SEL_MODCTL, 64'h16);
        rd(REG_SEL_MODCTL, 64'h16, "ctl_rd");
        wr(REG_SEL_FAN, 64'h5);
        rd(REG_SEL_FAN, {56'h0, FANV}, "fan_ro");
        for (i = 0; i < 8; i++)
        begin
            wr(REG_SEL_MODCTL, 64'h10 | 64'(i * 2));
            on_count(i == 0 ? PER : i * SLOT_CYC, "sw_duty");
        end
        // Interrupt held while clocks are off, snoop answered at once
        wr(REG_SEL_MODCTL, 64'h12);
        for (i = 0; i < 800 && clk_on !== 1'b0; i++) @(negedge sys_clk_i);
        int_req = 1'b1;
        snoop_req = 1'b1;
        @(negedge sys_clk_i);
        int_req = 1'b0;
        snoop_req = 1'b0;
        `CHK("snoop_ack", 1'b1, snoop_ack)
        for (i = 0; i < 800 && svc !== 1'b1; i++) @(negedge sys_clk_i);
        `CHK("int_svc", 1'b1, svc)
        // Auto duty wins over software duty
        auto_en = 1'b1;
        die_hot = 1'b1;
        repeat (10) @(negedge sys_clk_i);
        `CHK("hot_drive", 3'b011, {alert_n, alert_oe, thr})
        on_count(3 * SLOT_CYC, "auto_over_sw");
        wr(REG_SEL_MODCTL, 64'h0);
        on_count(3 * SLOT_CYC, "auto_duty");
        die_hot = 1'b0;
        t0 = cyc;
        for (i = 0; i < 200 && thr !== 1'b0; i++) @(negedge sys_clk_i);
        `CHK("hyst", 1'b1, (cyc - t0 >= HYST) && (cyc - t0 <= HYST + 12))
        repeat (3) @(negedge sys_clk_i);
        `CHK("cool_out", 4'b1001, {alert_n, alert_oe, thr, clk_on})
        `CHK("irq_off", 0, n_irq)
        // External pull on the hot alert wire
        irq_a = 1'b1;
        irq_d = 1'b1;
        vr_hot = 1'b1;
        for (i = 0; i < 20 && thr !== 1'b1; i++) @(negedge sys_clk_i);
        `CHK("ext_thr", 2'b10, {thr, alert_oe})
        repeat (50) @(negedge sys_clk_i);
        vr_hot = 1'b0;
        for (i = 0; i < 200 && thr !== 1'b0; i++) @(negedge sys_clk_i);
        repeat (3) @(negedge sys_clk_i);
        `CHK("ext_end", 1'b0, thr)
        `CHK("irq_both", 2, n_irq)
        // Clock enable low freezes the pin filter and the engine
        clk_en = 1'b0;
        vr_hot = 1'b1;
        repeat (20) @(negedge sys_clk_i);
        `CHK("frozen", 5'b00101, {thr, alert_oe, alert_n, hot_irq, n_irq == 2})
        vr_hot = 1'b0;
        clk_en = 1'b1;
        repeat (5) @(negedge sys_clk_i);
        // Hot without auto mode, then trip
        auto_en = 1'b0;
        die_hot = 1'b1;
        repeat (20) @(negedge sys_clk_i);
        `CHK("no_auto", 3'b010, {thr, alert_oe, alert_n})
        die_trip = 1'b1;
        for (i = 0; i < 10 && trip_n !== 1'b0; i++) @(negedge sys_clk_i);
        `CHK("trip", 2'b00, {trip_n, clk_on})
        die_trip = 1'b0;
        die_hot = 1'b0;
        repeat (20) @(negedge sys_clk_i);
        `CHK("trip_stays", 3'b000, {trip_n, clk_on, supply})
        `CHK("off_gap", 1'b1, max_off <= OFF_MAX_CYC)
        `CHK("svc_on_only", 0, svc_bad)
        tally_and_finish();
    end
endmodule // tct_top_tb
